// File: design/bhm_regs.vh
// register offsets, field positions, reset values and timing counts of the board health monitor
`ifndef BHM_REGS_VH
`define BHM_REGS_VH
// byte offsets on the avalon word bus
`define BHM_VOLT_BASE 12'h000
`define BHM_CURR_BASE 12'h040
`define BHM_VOLT_END 12'h024
`define BHM_CURR_END 12'h050
`define BHM_EXC_OFS 12'h060
`define BHM_CAUSE_OFS 12'h064
`define BHM_OPTIME_OFS 12'h068
`define BHM_ONTIME_OFS 12'h06C
`define BHM_BOOT_OFS 12'h070
`define BHM_TMIN_OFS 12'h074
`define BHM_TMAX_OFS 12'h078
`define BHM_WDCTL_OFS 12'h07C
`define BHM_WDKICK_OFS 12'h080
`define BHM_IRQST_OFS 12'h084
`define BHM_IRQMSK_OFS 12'h088
`define BHM_LOCK_OFS 12'h08C
`define BHM_NVM_BASE 12'h400
`define BHM_PROT_BASE 12'h800
`define BHM_PROT_END 12'h880
// restart cause codes
`define BHM_CAUSE_POWER 2'h0
`define BHM_CAUSE_WDOG 2'h1
`define BHM_CAUSE_EXT 2'h2
// status bit positions
`define BHM_IRQ_EXC 0
`define BHM_IRQ_SAMPLE 1
`define BHM_IRQ_TEMP 2
// fault codes
`define BHM_NO_FAULT_CODE 4'h0
`define BHM_FAULT_MIN 4'h2
`define BHM_FAULT_MAX 4'hA
// reset values
`define BHM_TMIN_RST 16'h7FFF
`define BHM_TMAX_RST 16'h8000
`define BHM_WD_RST 32'h00000000
// timing: 40 MHz clock
`define BHM_CLK_HZ 40000000
`define BHM_SAMPLE_MS 250
`define BHM_SAMPLE_CYC (`BHM_CLK_HZ / 1000 * `BHM_SAMPLE_MS)
`define BHM_SEC_CYC (`BHM_CLK_HZ)
`define BHM_MIN_SEC 60
// led blink timing
`define BHM_BLINK_MS 250
`define BHM_BLINK_CYC (`BHM_CLK_HZ / 1000 * `BHM_BLINK_MS)
`define BHM_GAP_SLOTS 4'h6
`endif

// File: design/bhm_monitor.v
// board health monitor: voltage, current, exceptions, counters, watchdog, storage
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "bhm_regs.vh"
module bhm_monitor
#(
  parameter SAMPLE_CYC = `BHM_SAMPLE_CYC, // current sample interval in cycles
  parameter SEC_CYC = `BHM_SEC_CYC, // cycles per second
  parameter BLINK_CYC = `BHM_BLINK_CYC // led blink half period in cycles
)
(
  input wire sys_clk_i, // 40 MHz clock
  input wire rst_i, // async reset, active high
  input wire [11:0] avs_address_i, // byte address
  input wire avs_read_i, // read request
  input wire avs_write_i, // write request
  input wire [31:0] avs_writedata_i, // write data
  input wire [3:0] avs_byteenable_i, // byte lanes
  output reg [31:0] avs_readdata_o, // read data
  output wire avs_waitrequest_o, // stall
  output wire [1:0] avs_response_o, // 00 ok, 10 slave error
  input wire [143:0] adc_volt_i, // nine 16-bit converter results, same clock
  input wire [15:0] board_temp_i, // board temperature, signed, same clock
  input wire [3:0] fault_code_i, // detected fault code, 0 none
  input wire sys_start_i, // pulse: system start (power-up done)
  input wire sw_reset_i, // pulse: software reset seen
  input wire ext_reset_n_i, // external reset pin, active low, async
  input wire power_loss_i, // level from power-loss latch, sampled at start
  output reg status_led_o, // status led, blink code
  output reg sys_reset_o, // pulse: reset the whole system
  output wire irq_o // level interrupt
);
  wire [143:0] volt_q;
  wire [63:0] curr_q;
  reg [1:0] curr_wp_r;
  reg [31:0] samp_cnt_r;
  reg [3:0] exc_r;
  reg [1:0] cause_r;
  reg [31:0] optime_r;
  reg [31:0] ontime_r;
  reg [31:0] boot_r;
  reg [31:0] sec_cnt_r;
  reg [5:0] min_sec_r;
  reg [15:0] tmin_r;
  reg [15:0] tmax_r;
  reg [31:0] wd_load_r;
  reg [31:0] wd_cnt_r;
  reg [2:0] irq_st_r;
  reg [2:0] irq_msk_r;
  reg lock_r;
  reg [31:0] nvm_r [0:255];
  reg [31:0] prot_r [0:31];
  reg [2:0] ext_sync_r;
  reg ext_state_r;
  reg rd_pend_r;
  reg err_r;
  reg [31:0] blink_cnt_r;
  reg [3:0] blink_slot_r;
  reg [3:0] blink_code_r;
  reg [1:0] blink_state_r;
  wire wr_acc;
  wire ext_fall;
  wire sample_tick;
  wire sec_tick;
  wire wd_kick;
  wire wd_expire;
  wire [15:0] temp_s;
  wire in_volt;
  wire in_curr;
  wire in_nvm;
  wire in_prot;
  wire [3:0] vidx;
  wire [2:0] excl_bits;
  wire mapped;
  genvar g;
  // blink states: next slot lit, next slot dark, gap between repeats
  localparam [1:0] BLK_GAP = 2'h0;
  localparam [1:0] BLK_ON = 2'h1;
  localparam [1:0] BLK_OFF = 2'h2;

  // reads take one wait cycle so read data comes from a flop
  assign avs_waitrequest_o = avs_read_i & ~rd_pend_r;
  assign wr_acc = avs_write_i;
  assign avs_response_o = err_r ? 2'h2 : 2'h0;
  assign in_volt = avs_address_i < `BHM_VOLT_END; // nine words
  assign in_curr = avs_address_i >= `BHM_CURR_BASE && avs_address_i < `BHM_CURR_END;
  assign in_nvm = avs_address_i >= `BHM_NVM_BASE && avs_address_i < `BHM_PROT_BASE;
  assign in_prot = avs_address_i >= `BHM_PROT_BASE && avs_address_i < `BHM_PROT_END;
  assign vidx = avs_address_i[5:2];
  assign mapped = in_volt | in_curr | in_nvm | in_prot
    | (avs_address_i >= `BHM_EXC_OFS && avs_address_i <= `BHM_LOCK_OFS);
  assign irq_o = |(irq_st_r & irq_msk_r);

  // external reset pin: three flops, edge counts when stages two and three agree
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_sync_r <= 3'h7;
      ext_state_r <= 1'b1;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[1:0], ext_reset_n_i};
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_state_r <= ext_sync_r[2];
    end
  end
  assign ext_fall = ext_state_r & ~ext_sync_r[2] & ~ext_sync_r[1];

  // free-running sample timer, independent of any bus traffic
  assign sample_tick = (samp_cnt_r == SAMPLE_CYC - 1);
  assign sec_tick = (sec_cnt_r == SEC_CYC - 1);
  assign wd_kick = wr_acc && avs_address_i == `BHM_WDKICK_OFS;
  assign wd_expire = (wd_load_r != 32'h0) && (wd_cnt_r == 32'h1);
  assign temp_s = board_temp_i; // only board temperature is watched
  assign excl_bits[`BHM_IRQ_EXC] = (fault_code_i != `BHM_NO_FAULT_CODE) && (fault_code_i != exc_r);
  assign excl_bits[`BHM_IRQ_SAMPLE] = sample_tick;
  assign excl_bits[`BHM_IRQ_TEMP] = ($signed(temp_s) < $signed(tmin_r))
    || ($signed(temp_s) > $signed(tmax_r));

  // one snapshot flop per converter channel, so a read never sees a half-changed word
  generate
    for (g = 0; g < 9; g = g + 1)
    begin : g_chan
      reg [15:0] val_r;
      always @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
          val_r <= 16'h0;
        else
          val_r <= adc_volt_i[16*g +: 16];
      end
      assign volt_q[16*g +: 16] = val_r;
    end
  endgenerate

  // four current slots loaded in turn by the sample tick; bus reads never gate them
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_slot
      localparam integer SLOT = g;
      reg [15:0] val_r;
      always @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
          val_r <= 16'h0;
        else if (sample_tick && {30'h0, curr_wp_r} == SLOT)
          val_r <= volt_q[143:128]; // channel 8 is current
      end
      assign curr_q[16*g +: 16] = val_r;
    end
  endgenerate

  // current ring, timers and counters
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      samp_cnt_r <= 32'h0;
      curr_wp_r <= 2'h0;
      sec_cnt_r <= 32'h0;
      min_sec_r <= 6'h0;
      optime_r <= 32'h0;
      ontime_r <= 32'h0;
      boot_r <= 32'h0;
      exc_r <= `BHM_NO_FAULT_CODE;
      cause_r <= `BHM_CAUSE_POWER;
      tmin_r <= `BHM_TMIN_RST;
      tmax_r <= `BHM_TMAX_RST;
      wd_cnt_r <= `BHM_WD_RST;
      sys_reset_o <= 1'b0;
    end
    else
    begin
      samp_cnt_r <= sample_tick ? 32'h0 : samp_cnt_r + 32'h1;
      if (sample_tick)
        curr_wp_r <= curr_wp_r + 2'h1; // slot order wraps, no time order
      sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
      if (sys_start_i || sw_reset_i || ext_fall)
        ontime_r <= 32'h0;
      else if (sec_tick)
        ontime_r <= ontime_r + 32'h1;
      if (sec_tick)
      begin
        // run time counted in whole minutes
        if (min_sec_r == `BHM_MIN_SEC - 1)
        begin
          min_sec_r <= 6'h0;
          optime_r <= optime_r + 32'h1;
        end
        else
          min_sec_r <= min_sec_r + 6'h1;
      end
      if (sys_start_i || sw_reset_i || ext_fall)
        boot_r <= boot_r + 32'h1;
      // latest fault wins; nothing in software can clear it
      if (fault_code_i >= `BHM_FAULT_MIN && fault_code_i <= `BHM_FAULT_MAX)
        exc_r <= fault_code_i;
      if ($signed(temp_s) < $signed(tmin_r))
        tmin_r <= temp_s;
      if ($signed(temp_s) > $signed(tmax_r))
        tmax_r <= temp_s;
      // restart cause
      if (wd_expire)
        cause_r <= `BHM_CAUSE_WDOG;
      else if (ext_fall)
        cause_r <= `BHM_CAUSE_EXT;
      else if (sys_start_i && power_loss_i)
        cause_r <= `BHM_CAUSE_POWER;
      // watchdog: zero load disables it
      if (wd_kick || (wr_acc && avs_address_i == `BHM_WDCTL_OFS))
        wd_cnt_r <= wd_kick ? wd_load_r : avs_writedata_i;
      else if (wd_cnt_r != 32'h0)
        wd_cnt_r <= wd_cnt_r - 32'h1;
      sys_reset_o <= wd_expire;
    end
  end

  // software registers and interrupt status
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wd_load_r <= `BHM_WD_RST;
      irq_st_r <= 3'h0;
      irq_msk_r <= 3'h0;
      lock_r <= 1'b0;
    end
    else
    begin
      // set wins over a write-one clear in the same cycle
      if (wr_acc && avs_address_i == `BHM_IRQST_OFS)
        irq_st_r <= (irq_st_r & ~avs_writedata_i[2:0]) | excl_bits;
      else
        irq_st_r <= irq_st_r | excl_bits;
      if (wr_acc && avs_address_i == `BHM_IRQMSK_OFS)
        irq_msk_r <= avs_writedata_i[2:0];
      if (wr_acc && avs_address_i == `BHM_WDCTL_OFS)
        wd_load_r <= avs_writedata_i;
      // lock is sticky until reset: protects region from bus writes
      if (wr_acc && avs_address_i == `BHM_LOCK_OFS && avs_writedata_i[0])
        lock_r <= 1'b1;
    end
  end

  // storage arrays, no reset so they map onto ram
  always @(posedge sys_clk_i)
  begin
    if (wr_acc && in_nvm)
      nvm_r[avs_address_i[9:2]] <= avs_writedata_i;
    if (wr_acc && in_prot && !lock_r)
      prot_r[avs_address_i[6:2]] <= avs_writedata_i;
  end

  // read data register; reads never touch the sample timer
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_pend_r <= 1'b0;
      err_r <= 1'b0;
      avs_readdata_o <= 32'h0;
    end
    else
    begin
      rd_pend_r <= avs_read_i & ~rd_pend_r;
      err_r <= avs_read_i & ~rd_pend_r & ~mapped;
      if (avs_read_i && !rd_pend_r)
      begin
        avs_readdata_o <= 32'h0;
        if (in_volt && vidx != 4'h8)
          avs_readdata_o <= {16'h0, volt_q[vidx*16 +: 16]};
        else if (in_curr)
          avs_readdata_o <= {16'h0, curr_q[16*avs_address_i[3:2] +: 16]};
        else if (in_nvm)
          avs_readdata_o <= nvm_r[avs_address_i[9:2]];
        else if (in_prot)
          avs_readdata_o <= prot_r[avs_address_i[6:2]];
        else
        begin
          case (avs_address_i)
            `BHM_EXC_OFS: avs_readdata_o <= {28'h0, exc_r};
            `BHM_CAUSE_OFS: avs_readdata_o <= {30'h0, cause_r};
            `BHM_OPTIME_OFS: avs_readdata_o <= optime_r;
            `BHM_ONTIME_OFS: avs_readdata_o <= ontime_r;
            `BHM_BOOT_OFS: avs_readdata_o <= boot_r;
            `BHM_TMIN_OFS: avs_readdata_o <= {{16{tmin_r[15]}}, tmin_r};
            `BHM_TMAX_OFS: avs_readdata_o <= {{16{tmax_r[15]}}, tmax_r};
            `BHM_WDCTL_OFS: avs_readdata_o <= wd_load_r;
            `BHM_IRQST_OFS: avs_readdata_o <= {29'h0, irq_st_r};
            `BHM_IRQMSK_OFS: avs_readdata_o <= {29'h0, irq_msk_r};
            `BHM_LOCK_OFS: avs_readdata_o <= {31'h0, lock_r};
            default: avs_readdata_o <= 32'h0;
          endcase
        end
      end
    end
  end

  // blink code: n lit slots, each followed by a dark slot, then seven dark slots;
  // the code is taken only at the end of a gap, so a burst is never cut short
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blink_cnt_r <= 32'h0;
      blink_slot_r <= 4'h0;
      blink_code_r <= 4'h0;
      blink_state_r <= BLK_GAP;
      status_led_o <= 1'b0;
    end
    else if (blink_cnt_r != BLINK_CYC - 1)
      blink_cnt_r <= blink_cnt_r + 32'h1;
    else
    begin
      blink_cnt_r <= 32'h0;
      case (blink_state_r)
        BLK_ON:
        begin
          status_led_o <= 1'b1;
          blink_state_r <= BLK_OFF;
        end
        BLK_OFF:
        begin
          status_led_o <= 1'b0;
          if (blink_slot_r == blink_code_r - 4'h1)
          begin
            blink_slot_r <= 4'h0;
            blink_state_r <= BLK_GAP;
          end
          else
          begin
            blink_slot_r <= blink_slot_r + 4'h1;
            blink_state_r <= BLK_ON;
          end
        end
        BLK_GAP:
        begin
          status_led_o <= 1'b0;
          if (blink_slot_r == `BHM_GAP_SLOTS)
          begin
            blink_slot_r <= 4'h0;
            blink_code_r <= exc_r; // same code as the register
            // code 0 keeps the led dark and just waits out another gap
            blink_state_r <= (exc_r == `BHM_NO_FAULT_CODE) ? BLK_GAP : BLK_ON;
          end
          else
            blink_slot_r <= blink_slot_r + 4'h1;
        end
        default:
        begin
          status_led_o <= 1'b0;
          blink_slot_r <= 4'h0;
          blink_state_r <= BLK_GAP;
        end
      endcase
    end
  end
endmodule // bhm_monitor

// File: testbench/bhm_monitor_properties.sv
// port checker for the board health monitor
`timescale 1ns/1ps
module bhm_monitor_properties
(
  input wire sys_clk_i, // clock
  input wire rst_i, // reset
  input wire [11:0] avs_address_i, // address
  input wire avs_read_i, // read
  input wire avs_write_i, // write
  input wire [31:0] avs_writedata_i, // data
  input wire avs_waitrequest_o, // stall
  input wire [1:0] avs_response_o, // response
  input wire status_led_o, // led
  input wire sys_reset_o, // system reset
  input wire irq_o // interrupt
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // one write of a value to one offset
  sequence wr_at(ad, v);
    avs_write_i && avs_address_i == ad && avs_writedata_i == v;
  endsequence
  read_stall_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read not stalled");
  write_nowait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  bad_addr_a: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h880 |-> avs_response_o == 2'h2)
    else $error("no error past protected area");
  wd_fire_a: assert property (wr_at(12'h07C, 32'h4) |-> ##[2:8] sys_reset_o)
    else $error("watchdog did not fire");
  wd_off_a: assert property (wr_at(12'h07C, 32'h0) |=> !sys_reset_o [*8])
    else $error("disabled watchdog fired");
  pulse_one_a: assert property ($rose(sys_reset_o) |=> !sys_reset_o)
    else $error("reset pulse too long");
  mask_off_a: assert property (wr_at(12'h088, 32'h0) |=> !irq_o)
    else $error("masked interrupt high");
  reset_quiet_a: assert property ($fell(rst_i) |-> !sys_reset_o && !irq_o && !status_led_o)
    else $error("outputs active after reset");
endmodule // bhm_monitor_properties

bind bhm_monitor bhm_monitor_properties u_bhm_monitor_properties
(
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
  .status_led_o(status_led_o), .sys_reset_o(sys_reset_o), .irq_o(irq_o)
);

// File: testbench/bhm_host_model.sv
// host model issuing register transfers to the monitor
`timescale 1ns/1ps
module bhm_host_model
(
  input wire sys_clk_i, // clock
  input wire avs_waitrequest_i, // stall
  input wire [31:0] avs_readdata_i, // read data
  input wire [1:0] avs_response_i, // response
  output reg [11:0] avs_address_o = 12'h000, // address
  output reg avs_read_o = 1'b0, // read
  output reg avs_write_o = 1'b0, // write
  output reg [31:0] avs_writedata_o = 32'h0, // data
  output wire [3:0] avs_byteenable_o // lanes
);
  integer hangs = 0;
  // monitor takes full words only
  assign avs_byteenable_o = 4'hF;
  // request held until waitrequest is seen low at an edge; bounded so a hang is counted
  task access(input reg w, input reg [11:0] a, input reg [31:0] d,
              output reg [31:0] q, output reg [1:0] r);
    integer n;
    begin
      @(posedge sys_clk_i);
      avs_address_o <= a;
      avs_writedata_o <= d;
      avs_write_o <= w;
      avs_read_o <= !w;
      n = 0;
      @(posedge sys_clk_i);
      while (avs_waitrequest_i !== 1'b0 && n < 40)
      begin
        n = n + 1;
        @(posedge sys_clk_i);
      end
      if (avs_waitrequest_i !== 1'b0)
        hangs = hangs + 1;
      q = avs_readdata_i;
      r = avs_response_i;
      avs_write_o <= 1'b0;
      avs_read_o <= 1'b0;
    end
  endtask
endmodule // bhm_host_model

// File: testbench/test_board_health_monitor.sv
// self-checking bench for the board health monitor
`timescale 1ns/1ps
module test_board_health_monitor;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [143:0] adc = 144'h0;
  reg [15:0] temp = 16'h000A;
  reg [3:0] fault = 4'h0;
  reg start = 1'b0;
  reg swr = 1'b0;
  reg extn = 1'b1;
  reg ploss = 1'b1;
  wire [11:0] addr;
  wire rd_en, wr_en, stall, led, sysrst, irq;
  wire [31:0] wdata, rdata;
  wire [3:0] be;
  wire [1:0] resp;
  integer failures = 0;
  integer comparisons = 0;
  integer i, k, cyc, pulses, rises;
  reg led_q = 1'b0;
  reg [31:0] q, a, m;
  reg [1:0] r;
  reg [15:0] cur_q[$];
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // run time and system reset pulses seen
  always @(posedge clk)
  begin
    cyc <= rst ? 0 : cyc + 1;
    pulses <= rst ? 0 : pulses + (sysrst === 1'b1);
    led_q <= led;
    rises <= rst ? 0 : rises + (led === 1'b1 && led_q === 1'b0);
  end
  bhm_monitor #(.SAMPLE_CYC(20), .SEC_CYC(10), .BLINK_CYC(2)) u_bhm_monitor
  (
    .sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(stall), .avs_response_o(resp),
    .adc_volt_i(adc), .board_temp_i(temp), .fault_code_i(fault), .sys_start_i(start),
    .sw_reset_i(swr), .ext_reset_n_i(extn), .power_loss_i(ploss),
    .status_led_o(led), .sys_reset_o(sysrst), .irq_o(irq)
  );
  bhm_host_model u_bhm_host_model
  (
    .sys_clk_i(clk), .avs_waitrequest_i(stall), .avs_readdata_i(rdata),
    .avs_response_i(resp), .avs_address_o(addr), .avs_read_o(rd_en),
    .avs_write_o(wr_en), .avs_writedata_o(wdata), .avs_byteenable_o(be)
  );
  task tk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task rd(input [11:0] ad);
    u_bhm_host_model.access(1'b0, ad, 32'h0, q, r);
  endtask
  task rc(input [11:0] ad, input [31:0] e);
    begin
      rd(ad);
      chk(q, e);
    end
  endtask
  task wr(input [11:0] ad, input [31:0] d);
    u_bhm_host_model.access(1'b1, ad, d, q, r);
  endtask
  task irq_is(input [31:0] e);
    begin
      tk(1);
      chk({31'h0, irq}, e);
    end
  endtask
  // 0 start, 1 software reset, 2 external reset pin
  task pulse(input integer s);
    begin
      tk(1);
      start <= (s == 0);
      swr <= (s == 1);
      extn <= (s != 2);
      tk(1);
      start <= 1'b0;
      swr <= 1'b0;
      tk(4);
      extn <= 1'b1;
      tk(6);
    end
  endtask
  task print_verdict;
    begin
      failures = failures + u_bhm_host_model.hangs;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    m = $urandom(1);
    tk(8);
    rst <= 1'b0;
    for (i = 0; i < 9; i = i + 1)
    begin
      m = $urandom;
      adc[16*i +: 16] <= m[15:0];
    end
    pulse(0);
    ploss <= 1'b0;
    rc(12'h064, 32'h0);
    rc(12'h070, 32'h1);
    for (i = 0; i < 9; i = i + 1)
    begin
      a = 4 * i;
      rc(a[11:0], (i < 8) ? {16'h0, adc[16*i +: 16]} : 32'h0);
    end
    // reads land while sampling runs, so slots must still all hold the new value
    for (k = 0; k < 2; k = k + 1)
    begin
      m = $urandom;
      adc[143:128] <= m[15:0];
      cur_q.push_back(m[15:0]);
      tk(100);
      for (i = 0; i < 4; i = i + 1)
      begin
        a = 64 + 4 * i;
        rc(a[11:0], {16'h0, cur_q[$]});
      end
    end
    chk(rises, 0);
    for (k = 2; k < 11; k = k + 1)
    begin
      fault <= k[3:0];
      tk(4);
      rc(12'h060, k);
    end
    fault <= 4'h0;
    wr(12'h060, 32'h0);
    rc(12'h060, 32'hA);
    wr(12'h088, 32'h1);
    irq_is(1);
    wr(12'h084, 32'h1);
    irq_is(0);
    fault <= 4'h3;
    tk(4);
    irq_is(1);
    wr(12'h088, 32'h0);
    irq_is(0);
    wr(12'h07C, 32'd30);
    for (i = 0; i < 5; i = i + 1)
    begin
      tk(10);
      wr(12'h080, 32'h0);
    end
    wr(12'h07C, 32'h0);
    tk(40);
    chk(pulses, 0);
    wr(12'h07C, 32'h4);
    tk(12);
    chk(pulses, 1);
    rc(12'h064, 32'h1);
    // code 3 repeats every 3 lit + 3 dark + 7 gap slots of 2 cycles: two frames
    a = rises;
    tk(52);
    chk(rises - a, 6);
    pulse(1);
    rc(12'h070, 32'h2);
    pulse(2);
    rc(12'h064, 32'h2);
    rc(12'h070, 32'h3);
    rd(12'h06C);
    a = q;
    chk({31'h0, a <= 32'd2}, 1);
    tk(50);
    rd(12'h06C);
    chk({31'h0, q - a >= 4 && q - a <= 6}, 1);
    tk(1300);
    rd(12'h068);
    chk({31'h0, q * 600 <= cyc && cyc < q * 600 + 700}, 1);
    temp <= 16'hFFFB;
    tk(3);
    temp <= 16'h001E;
    tk(3);
    rc(12'h074, 32'hFFFFFFFB);
    rc(12'h078, 32'h0000001E);
    m = $urandom;
    wr(12'h400, m);
    wr(12'h7FC, ~m);
    rc(12'h400, m);
    rc(12'h7FC, ~m);
    wr(12'h800, m);
    wr(12'h08C, 32'h1);
    wr(12'h800, ~m);
    rc(12'h800, m);
    rd(12'h880);
    chk({30'h0, r}, 32'h2);
    print_verdict;
  end
  // hang guard
  initial
  begin
    tk(30000);
    failures = failures + 1;
    print_verdict;
  end
endmodule // test_board_health_monitor
